// file: design/ext_ctrl_io.sv
// External control port: pin decoding, output relay, step sequencer
// Functional notes
// - The power status pin is low in reset and high while powered.
// - The output status pin shows 0 for disabled, 1 for enabled output.
// - The limiter status pin is 1 while the current limiter acts.
// - The busy pin is 1 while the controller is busy, else 0.
// - Two step pins carry the code of the step being executed.
// - A falling edge on the output-off pin disables the output.
// - A falling edge on the output-on pin enables the output.
// - A falling edge on the stop pin ends the running sequence.
// - A falling edge on the hold pin pauses the sequence at its step.
// - A falling edge on branch pin A jumps to the step's target A.
// - A falling edge on branch pin B jumps to the step's target B.
// - Actions may lag inputs by about 50 ms, plus relay delay.
// - The sequence runs only while the output is enabled.
// - A branch ends the step early and enters the target at once.
`timescale 1ns/1ps
module ext_ctrl_io #(
	parameter int unsigned RELAY_CYCLES = ext_ctrl_pkg::RESP_MAX_CYCLES,
	parameter int unsigned TICK_CYCLES  = ext_ctrl_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// AXI4-Lite write channels
	input  wire logic [7:0]                 awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]                 araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	// Control connector
	input  wire ext_ctrl_pkg::ctrl_pins_t   ctrl_pins,
	output ext_ctrl_pkg::status_pins_t      status,
	// Interrupt
	output logic                            irq
);
	logic [7:0]                 pin_lvl;
	logic [7:0]                 pin_fall;
	logic [4:0]                 sw_cmd;
	logic                       ev_on, ev_off, ev_start, ev_stop, ev_hold;
	logic                       out_cmd, out_en, relay_busy;
	logic [31:0]                relay_cnt;
	ext_ctrl_pkg::seq_state_t   state;
	logic [3:0]                 step;
	logic [31:0]                tick_cnt;
	logic [15:0]                dur_cnt;
	ext_ctrl_pkg::step_entry_t  cur, prog_rd;
	logic                       tick_wrap, step_end, seq_abort;
	logic                       br_a_go, br_b_go, ev_done, ev_branch;
	logic                       out_en_q, limit_q;
	logic [3:0]                 irq_stat, irq_mask, next_irq_stat;
	logic [3:0]                 prog_addr;
	logic                       aw_full, w_full, wr_go, rd_go, tbl_we;
	logic [7:0]                 awaddr_q;
	logic [31:0]                wdata_q, rd_word;
	logic [3:0]                 wstrb_q;

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = a == ext_ctrl_pkg::ADDR_CTRL
			|| a == ext_ctrl_pkg::ADDR_STATUS
			|| a == ext_ctrl_pkg::ADDR_IRQ_STAT
			|| a == ext_ctrl_pkg::ADDR_IRQ_MASK
			|| a == ext_ctrl_pkg::ADDR_PROG_ADDR
			|| a == ext_ctrl_pkg::ADDR_PROG_DATA;
	endfunction : reg_mapped

	edge_sync #(
		.W    (8),
		.IDLE (ext_ctrl_pkg::PIN_IDLE)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    (ctrl_pins),
		.level   (pin_lvl),
		.fall    (pin_fall)
	);

	step_table #(
		.N  (ext_ctrl_pkg::STEP_COUNT),
		.AW (ext_ctrl_pkg::STEP_W)
	) u_table (
		.aclk    (aclk),
		.we      (tbl_we),
		.waddr   (prog_addr),
		.wdata   (wdata_q[ext_ctrl_pkg::ENTRY_W-1:0]),
		.raddr_a (step),
		.rdata_a (cur),
		.raddr_b (prog_addr),
		.rdata_b (prog_rd)
	);

	// Pin edges and software commands are merged into one event set
	assign ev_off   = pin_fall[ext_ctrl_pkg::PIN_OFF]
		| sw_cmd[ext_ctrl_pkg::CTRL_OFF_BIT];
	assign ev_on    = pin_fall[ext_ctrl_pkg::PIN_ON]
		| sw_cmd[ext_ctrl_pkg::CTRL_ON_BIT];
	assign ev_start = pin_fall[ext_ctrl_pkg::PIN_START]
		| sw_cmd[ext_ctrl_pkg::CTRL_START_BIT];
	assign ev_stop  = pin_fall[ext_ctrl_pkg::PIN_STOP]
		| sw_cmd[ext_ctrl_pkg::CTRL_STOP_BIT];
	assign ev_hold  = pin_fall[ext_ctrl_pkg::PIN_HOLD]
		| sw_cmd[ext_ctrl_pkg::CTRL_HOLD_BIT];

	// Off wins over a simultaneous on, the safe choice
	always_ff @(posedge aclk) begin
		if (!aresetn)
			out_cmd <= 1'b0;
		else if (ev_off)
			out_cmd <= 1'b0;
		else if (ev_on)
			out_cmd <= 1'b1;
	end

	// Relay settle time before the output state is reported
	assign relay_busy = out_cmd != out_en;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_en    <= 1'b0;
			relay_cnt <= 32'h0000_0000;
		end else if (!relay_busy) begin
			relay_cnt <= 32'h0000_0000;
		end else if (relay_cnt == 32'(RELAY_CYCLES - 1)) begin
			out_en    <= out_cmd;
			relay_cnt <= 32'h0000_0000;
		end else begin
			relay_cnt <= relay_cnt + 32'h0000_0001;
		end
	end

	assign tick_wrap = tick_cnt == 32'(TICK_CYCLES - 1);
	assign step_end  = tick_wrap
		&& ({1'b0, dur_cnt} + 17'h0_0001 >= {1'b0, cur.dur});
	assign seq_abort = ev_stop | ev_off | ~out_en;
	assign br_a_go   = pin_fall[ext_ctrl_pkg::PIN_BR_A]
		&& cur.branch_target_a != 4'h0;
	assign br_b_go   = pin_fall[ext_ctrl_pkg::PIN_BR_B]
		&& cur.branch_target_b != 4'h0;
	assign ev_done   = state == ext_ctrl_pkg::SEQ_RUN && !seq_abort
		&& !br_a_go && !br_b_go && !ev_hold && step_end && cur.last;
	assign ev_branch = state == ext_ctrl_pkg::SEQ_RUN && !seq_abort
		&& (br_a_go || br_b_go);

	// Sequencer; abort beats branch beats hold beats timing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state    <= ext_ctrl_pkg::SEQ_IDLE;
			step     <= 4'h0;
			tick_cnt <= 32'h0000_0000;
			dur_cnt  <= 16'h0000;
		end else begin
			unique case (state)
				ext_ctrl_pkg::SEQ_IDLE: begin
					if (ev_start && out_en && !ev_off) begin
						state    <= ext_ctrl_pkg::SEQ_RUN;
						step     <= 4'h0;
						tick_cnt <= 32'h0000_0000;
						dur_cnt  <= 16'h0000;
					end
				end
				ext_ctrl_pkg::SEQ_RUN: begin
					if (seq_abort) begin
						state <= ext_ctrl_pkg::SEQ_IDLE;
					end else if (br_a_go || br_b_go) begin
						step     <= br_a_go ? cur.branch_target_a
							: cur.branch_target_b;
						tick_cnt <= 32'h0000_0000;
						dur_cnt  <= 16'h0000;
					end else if (ev_hold) begin
						state <= ext_ctrl_pkg::SEQ_HOLD;
					end else if (step_end) begin
						tick_cnt <= 32'h0000_0000;
						dur_cnt  <= 16'h0000;
						if (cur.last)
							state <= ext_ctrl_pkg::SEQ_IDLE;
						else
							step <= cur.next;
					end else if (tick_wrap) begin
						tick_cnt <= 32'h0000_0000;
						dur_cnt  <= dur_cnt + 16'h0001;
					end else begin
						tick_cnt <= tick_cnt + 32'h0000_0001;
					end
				end
				ext_ctrl_pkg::SEQ_HOLD: begin
					if (seq_abort)
						state <= ext_ctrl_pkg::SEQ_IDLE;
					else if (ev_start)
						state <= ext_ctrl_pkg::SEQ_RUN;
				end
				default: state <= ext_ctrl_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Connector outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else begin
			status.power_on     <= 1'b1;
			status.out_enabled  <= out_en;
			status.limit_active <= pin_lvl[ext_ctrl_pkg::PIN_LIMIT];
			status.busy         <= relay_busy;
			status.step_code    <= state == ext_ctrl_pkg::SEQ_IDLE
				? 2'h0 : cur.code;
		end
	end

	// Sticky interrupt flags; a new event beats the read clear
	always_comb begin
		next_irq_stat = irq_stat;
		if (rd_go && araddr == ext_ctrl_pkg::ADDR_IRQ_STAT)
			next_irq_stat = 4'h0;
		next_irq_stat[ext_ctrl_pkg::IRQ_DONE_BIT]   |= ev_done;
		next_irq_stat[ext_ctrl_pkg::IRQ_BRANCH_BIT] |= ev_branch;
		next_irq_stat[ext_ctrl_pkg::IRQ_OUTEN_BIT]  |= out_en ^ out_en_q;
		next_irq_stat[ext_ctrl_pkg::IRQ_LIMIT_BIT]  |=
			pin_lvl[ext_ctrl_pkg::PIN_LIMIT] & ~limit_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 4'h0;
			out_en_q <= 1'b0;
			limit_q  <= 1'b0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			out_en_q <= out_en;
			limit_q  <= pin_lvl[ext_ctrl_pkg::PIN_LIMIT];
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	// Write path: address and data latched in either order
	assign wr_go  = aw_full && w_full && !bvalid;
	assign tbl_we = wr_go && awaddr_q == ext_ctrl_pkg::ADDR_PROG_DATA
		&& wstrb_q == 4'hF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			aw_full  <= 1'b0;
			w_full   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= ext_ctrl_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				aw_full  <= 1'b1;
				awready  <= 1'b0;
			end
			if (wvalid && wready) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				w_full  <= 1'b1;
				wready  <= 1'b0;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= reg_mapped(awaddr_q) ? ext_ctrl_pkg::RESP_OKAY
					: ext_ctrl_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Register writes; command bits last exactly one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_cmd    <= 5'h00;
			irq_mask  <= ext_ctrl_pkg::IRQ_MASK_RST;
			prog_addr <= 4'h0;
		end else begin
			sw_cmd <= 5'h00;
			if (wr_go && wstrb_q[0]) begin
				unique case (awaddr_q)
					ext_ctrl_pkg::ADDR_CTRL:
						sw_cmd <= wdata_q[ext_ctrl_pkg::CTRL_W-1:0];
					ext_ctrl_pkg::ADDR_IRQ_MASK:
						irq_mask <= wdata_q[ext_ctrl_pkg::IRQ_W-1:0];
					ext_ctrl_pkg::ADDR_PROG_ADDR:
						prog_addr <= wdata_q[ext_ctrl_pkg::STEP_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// Read path
	assign rd_go = arvalid && arready;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (araddr)
			ext_ctrl_pkg::ADDR_STATUS: begin
				rd_word[ext_ctrl_pkg::ST_CMD_BIT]   = out_cmd;
				rd_word[ext_ctrl_pkg::ST_OUTEN_BIT] = out_en;
				rd_word[ext_ctrl_pkg::ST_BUSY_BIT]  = relay_busy;
				rd_word[ext_ctrl_pkg::ST_LIMIT_BIT] =
					pin_lvl[ext_ctrl_pkg::PIN_LIMIT];
				rd_word[ext_ctrl_pkg::ST_STATE_LSB +: 2] = state;
				rd_word[ext_ctrl_pkg::ST_STEP_LSB +: 4]  = step;
			end
			ext_ctrl_pkg::ADDR_IRQ_STAT: rd_word[3:0] = irq_stat;
			ext_ctrl_pkg::ADDR_IRQ_MASK: rd_word[3:0] = irq_mask;
			ext_ctrl_pkg::ADDR_PROG_ADDR: rd_word[3:0] = prog_addr;
			ext_ctrl_pkg::ADDR_PROG_DATA:
				rd_word[ext_ctrl_pkg::ENTRY_W-1:0] = prog_rd;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= ext_ctrl_pkg::RESP_OKAY;
		end else if (rd_go) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= reg_mapped(araddr) ? ext_ctrl_pkg::RESP_OKAY
				: ext_ctrl_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	a_power_after_reset: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> status.power_on)
		else $error("power status low after reset");
	a_outen_pin_follows: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$changed(out_en) |=> status.out_enabled == $past(out_en))
		else $error("output status pin lags enable");
	a_limit_pin_rise: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_pins.limit) |-> ##[3:5] status.limit_active)
		else $error("limiter status not raised");
	a_busy_during_relay: assert property (
		@(posedge aclk) disable iff (!aresetn)
		relay_busy ##1 relay_busy |-> status.busy)
		else $error("busy low while relay settles");
	a_step_code_idle: assert property (
		@(posedge aclk) disable iff (!aresetn)
		state == ext_ctrl_pkg::SEQ_IDLE ##1 $stable(state)
		|-> status.step_code == 2'h0)
		else $error("step code set while idle");
	a_off_disables: assert property (
		@(posedge aclk) disable iff (!aresetn)
		pin_fall[ext_ctrl_pkg::PIN_OFF] |=> !out_cmd)
		else $error("output off edge ignored");
	a_on_enables: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ev_on && !ev_off |=> out_cmd)
		else $error("output on edge ignored");
	a_stop_ends_run: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ev_stop && state != ext_ctrl_pkg::SEQ_IDLE
		|=> state == ext_ctrl_pkg::SEQ_IDLE)
		else $error("stop did not end sequence");
	a_hold_keeps_step: assert property (
		@(posedge aclk) disable iff (!aresetn)
		state == ext_ctrl_pkg::SEQ_RUN && ev_hold && !seq_abort
		&& !br_a_go && !br_b_go
		|=> state == ext_ctrl_pkg::SEQ_HOLD && $stable(step))
		else $error("hold did not pause at step");
	a_branch_a_jump: assert property (
		@(posedge aclk) disable iff (!aresetn)
		state == ext_ctrl_pkg::SEQ_RUN && !seq_abort && br_a_go
		|=> step == $past(cur.branch_target_a) && dur_cnt == 16'h0000)
		else $error("branch A target not taken");
	a_branch_b_jump: assert property (
		@(posedge aclk) disable iff (!aresetn)
		state == ext_ctrl_pkg::SEQ_RUN && !seq_abort && br_b_go
		&& !br_a_go |=> step == $past(cur.branch_target_b))
		else $error("branch B target not taken");
	a_relay_bounded: assert property (
		@(posedge aclk) disable iff (!aresetn)
		relay_cnt < RELAY_CYCLES)
		else $error("relay delay overran");
	a_run_needs_output: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!out_en |=> state == ext_ctrl_pkg::SEQ_IDLE)
		else $error("sequence runs with output off");
	a_start_begins: assert property (
		@(posedge aclk) disable iff (!aresetn)
		state == ext_ctrl_pkg::SEQ_IDLE && ev_start && out_en && !ev_off
		|=> state == ext_ctrl_pkg::SEQ_RUN && step == 4'h0)
		else $error("start did not begin sequence");
	a_single_edge_pulse: assert property (
		@(posedge aclk) disable iff (!aresetn)
		|pin_fall |=> (pin_fall & $past(pin_fall)) == 8'h00)
		else $error("one pin edge gave two pulses");
endmodule : ext_ctrl_io

// file: include/ext_ctrl_pkg.sv
// Shared constants and types for the external control port block
package ext_ctrl_pkg;
	// Timing
	localparam int unsigned CLK_FREQ_HZ     = 40_000_000;
	localparam int unsigned RESP_MAX_MS     = 50;
	localparam int unsigned RESP_MAX_CYCLES =
		RESP_MAX_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = TICK_MS * (CLK_FREQ_HZ / 1000);
	// Step program
	localparam int unsigned STEP_COUNT = 16;
	localparam int unsigned STEP_W     = 4;
	localparam int unsigned ENTRY_W    = 31;
	// Register map
	localparam int unsigned ADDR_W         = 8;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0C;
	localparam logic [7:0]  ADDR_PROG_ADDR = 8'h10;
	localparam logic [7:0]  ADDR_PROG_DATA = 8'h14;
	// Control register command bits
	localparam int unsigned CTRL_ON_BIT    = 0;
	localparam int unsigned CTRL_OFF_BIT   = 1;
	localparam int unsigned CTRL_START_BIT = 2;
	localparam int unsigned CTRL_STOP_BIT  = 3;
	localparam int unsigned CTRL_HOLD_BIT  = 4;
	localparam int unsigned CTRL_W         = 5;
	// Status register fields
	localparam int unsigned ST_CMD_BIT   = 0;
	localparam int unsigned ST_OUTEN_BIT = 1;
	localparam int unsigned ST_BUSY_BIT  = 2;
	localparam int unsigned ST_LIMIT_BIT = 3;
	localparam int unsigned ST_STATE_LSB = 4;
	localparam int unsigned ST_STEP_LSB  = 8;
	// Interrupt bits
	localparam int unsigned IRQ_DONE_BIT   = 0;
	localparam int unsigned IRQ_BRANCH_BIT = 1;
	localparam int unsigned IRQ_OUTEN_BIT  = 2;
	localparam int unsigned IRQ_LIMIT_BIT  = 3;
	localparam int unsigned IRQ_W          = 4;
	localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Pin vector indices and idle levels
	localparam int unsigned PIN_OFF   = 0;
	localparam int unsigned PIN_ON    = 1;
	localparam int unsigned PIN_START = 2;
	localparam int unsigned PIN_STOP  = 3;
	localparam int unsigned PIN_HOLD  = 4;
	localparam int unsigned PIN_BR_A  = 5;
	localparam int unsigned PIN_BR_B  = 6;
	localparam int unsigned PIN_LIMIT = 7;
	localparam logic [7:0]  PIN_IDLE  = 8'h7F;

	typedef struct packed {
		logic limit;
		logic branch_b_n;
		logic branch_a_n;
		logic hold_n;
		logic stop_n;
		logic start_n;
		logic out_on_n;
		logic out_off_n;
	} ctrl_pins_t;

	typedef struct packed {
		logic       power_on;
		logic       out_enabled;
		logic       limit_active;
		logic       busy;
		logic [1:0] step_code;
	} status_pins_t;

	typedef struct packed {
		logic [1:0]  code;
		logic        last;
		logic [3:0]  branch_target_b;
		logic [3:0]  branch_target_a;
		logic [3:0]  next;
		logic [15:0] dur;
	} step_entry_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_RUN  = 2'h1,
		SEQ_HOLD = 2'h2
	} seq_state_t;
endpackage : ext_ctrl_pkg

// file: design/edge_sync.sv
// Three-stage pin synchroniser with settled levels and falling-edge pulses
`timescale 1ns/1ps
module edge_sync #(
	parameter int unsigned    W    = 8,
	parameter logic [W-1:0]   IDLE = '1
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Raw pins and conditioned results
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] level,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta;
	logic [W-1:0] sync2;
	logic [W-1:0] sync3;

	// Idle reset values so start-up shows no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta  <= IDLE;
			sync2 <= IDLE;
			sync3 <= IDLE;
		end else begin
			meta  <= pins;
			sync2 <= meta;
			sync3 <= sync2;
		end
	end

	// A change counts only once two stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn)
			level <= IDLE;
		else
			level <= (sync2 & sync3) | (level & (sync2 ^ sync3));
	end

	assign fall = level & ~sync2 & ~sync3;
endmodule : edge_sync

// file: design/step_table.sv
// Sequence step program memory, one write port and two read ports
`timescale 1ns/1ps
module step_table #(
	parameter int unsigned N  = 16,
	parameter int unsigned AW = 4
) (
	// Clock
	input  wire logic                      aclk,
	// Write port
	input  wire logic                      we,
	input  wire logic [AW-1:0]             waddr,
	input  wire ext_ctrl_pkg::step_entry_t wdata,
	// Read ports
	input  wire logic [AW-1:0]             raddr_a,
	output ext_ctrl_pkg::step_entry_t      rdata_a,
	input  wire logic [AW-1:0]             raddr_b,
	output ext_ctrl_pkg::step_entry_t      rdata_b
);
	ext_ctrl_pkg::step_entry_t mem [N];

	// Contents are software-loaded; no reset keeps this a plain RAM
	always_ff @(posedge aclk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];
endmodule : step_table

// file: verif/pin_driver.sv
// Model of the outside controller driving the control connector pins
`timescale 1ns/1ps
module pin_driver (
	// Clock
	input  wire logic              aclk,
	// Connector pins
	output ext_ctrl_pkg::ctrl_pins_t pins
);
	logic [7:0] pv = ext_ctrl_pkg::PIN_IDLE;

	assign pins = ext_ctrl_pkg::ctrl_pins_t'(pv);

	// Held 6 cycles each way, well past the synchroniser's need
	task automatic fall(input int idx);
		@(posedge aclk);
		pv[idx] <= 1'b0;
		repeat (6) @(posedge aclk);
		pv[idx] <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : fall

	task automatic set_limit(input logic v);
		@(posedge aclk);
		pv[ext_ctrl_pkg::PIN_LIMIT] <= v;
	endtask : set_limit
endmodule : pin_driver

// file: verif/tb.sv
// Self-checking bench for the external control port
`timescale 1ns/1ps
module tb;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic [1:0] rs;
	ext_ctrl_pkg::ctrl_pins_t ctrl_pins;
	ext_ctrl_pkg::status_pins_t status;
	int n_mismatch = 0, check_count = 0, cycles = 0, i;

	initial forever #12.5 aclk = ~aclk;

	ext_ctrl_io #(.RELAY_CYCLES(8), .TICK_CYCLES(4)) ext_ctrl_io_i (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ctrl_pins(ctrl_pins), .status(status), .irq(irq));

	pin_driver pin_driver_i (.aclk(aclk), .pins(ctrl_pins));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
		chk(bresp, ext_ctrl_pkg::RESP_OKAY);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask : axi_rd

	task automatic settle;
		repeat (30) @(posedge aclk);
	endtask : settle

	task automatic pulse(input int idx);
		pin_driver_i.fall(idx);
		settle();
	endtask : pulse

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(status.power_on, 1'b1);
		chk(status.out_enabled, 1'b0);
		chk(status.busy, 1'b0);
		// Steps: 0 runs, 2 and 3 are branch targets
		axi_wr(ext_ctrl_pkg::ADDR_PROG_ADDR, 32'h0000_0000);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_DATA, 32'h2321_0064);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_ADDR, 32'h0000_0001);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_DATA, 32'h3000_0064);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_ADDR, 32'h0000_0002);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_DATA, 32'h5000_0064);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_ADDR, 32'h0000_0003);
		axi_wr(ext_ctrl_pkg::ADDR_PROG_DATA, 32'h7000_001E);
		axi_rd(8'h20);
		chk(rs, ext_ctrl_pkg::RESP_SLVERR);
		chk(rd, 32'h0000_0000);
		axi_rd(ext_ctrl_pkg::ADDR_PROG_DATA);
		chk(rd, 32'h7000_001E);
		$display("test registers done");
		pulse(ext_ctrl_pkg::PIN_START);
		chk(status.step_code, 2'h0);
		fork pin_driver_i.fall(ext_ctrl_pkg::PIN_ON); join_none
		for (i = 0; i < 40 && status.busy !== 1'b1; i++) @(posedge aclk);
		chk(status.busy, 1'b1);
		for (i = 0; i < 40 && status.out_enabled !== 1'b1; i++)
			@(posedge aclk);
		settle();
		chk({status.out_enabled, status.busy}, 2'b10);
		$display("test output on done");
		pulse(ext_ctrl_pkg::PIN_START);
		chk(status.step_code, 2'h1);
		pulse(ext_ctrl_pkg::PIN_BR_A);
		chk(status.step_code, 2'h2);
		pulse(ext_ctrl_pkg::PIN_HOLD);
		axi_rd(ext_ctrl_pkg::ADDR_STATUS);
		chk(rd[5:4], 2'h2);
		chk(rd[11:8], 4'h2);
		pulse(ext_ctrl_pkg::PIN_STOP);
		axi_rd(ext_ctrl_pkg::ADDR_STATUS);
		chk({rd[5:4], status.step_code}, 4'h0);
		$display("test sequence control done");
		axi_wr(ext_ctrl_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		axi_rd(ext_ctrl_pkg::ADDR_IRQ_MASK);
		chk(rd, 32'h0000_0001);
		axi_rd(ext_ctrl_pkg::ADDR_IRQ_STAT);
		pulse(ext_ctrl_pkg::PIN_START);
		chk(irq, 1'b0);
		pulse(ext_ctrl_pkg::PIN_BR_B);
		chk(status.step_code, 2'h3);
		repeat (150) @(posedge aclk);
		chk({irq, status.step_code}, 3'b100);
		axi_rd(ext_ctrl_pkg::ADDR_IRQ_STAT);
		chk(rd, 32'h0000_0003);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		$display("test branch and interrupt done");
		pin_driver_i.set_limit(1'b1);
		settle();
		chk(status.limit_active, 1'b1);
		pin_driver_i.set_limit(1'b0);
		pulse(ext_ctrl_pkg::PIN_OFF);
		for (i = 0; i < 40 && status.out_enabled !== 1'b0; i++)
			@(posedge aclk);
		chk(status.out_enabled, 1'b0);
		chk(status.limit_active, 1'b0);
		$display("test limit and output off done");
		// Software on command, read back while the relay still settles
		axi_wr(ext_ctrl_pkg::ADDR_CTRL, 32'h0000_0001);
		axi_rd(ext_ctrl_pkg::ADDR_STATUS);
		chk(rd[2:0], 3'b101);
		// Reset while the relay settles must drop the pending output command
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({status, irq}, 7'b100_0000);
		repeat (20) @(posedge aclk);
		chk(status.out_enabled, 1'b0);
		$display("test software command and reset done");
		end_sim();
	end
endmodule : tb
